//--- rtl/smi_event_trigger.sv
`timescale 1ns/100ps
// Function
// - a watchdog event fires when the terminal bus stops addressing us, and its command is sent.
// - rising and falling edges on local input one are two events with their own command.
// - rising and falling edges on local input two are two events with their own command.
// - an event mapped to none sends nothing on the motor bus.
// - Up sends the command driving all motors to the upper end position.
// - Down sends the command driving all motors to the lower end position.
// - Stop sends the command halting motor operation.
// - goto preset one sends the command to the first stored motor position.
// - goto preset two sends the command to the second stored motor position.
// - input image is a 16-bit status word plus data-in bytes to byte 23; output image a 16-bit control word plus data-out bytes.
// - while local input activity is present, commands requested by the controller image are blocked.
module smi_event_trigger
	import smi_pkg::*;
#(
	parameter int unsigned WD_LIMIT_DEFAULT = WD_CYCLES,
	parameter int unsigned BIT_CYCLES       = SMI_BIT_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        bus_access,
	input  wire logic        local_input_one,
	input  wire logic        local_input_two,
	output logic             smi_tx,
	output logic             input_active,
	output logic             irq
);

	// ==========================================================
	// state
	logic [14:0] cmd_map;
	logic [4:0]  irq_status;
	logic [4:0]  irq_mask;
	logic [15:0] ctrl_word;
	logic [7:0]  data_out [IMAGE_BYTES];
	logic [7:0]  data_in  [IMAGE_BYTES];
	logic [15:0] status_word;
	logic [31:0] wd_limit;
	logic [31:0] wd_count;
	logic        wd_tripped;
	logic [4:0]  pending;
	logic        host_pending;
	logic [7:0]  host_code;
	logic [7:0]  last_sent;
	logic [4:0]  data_out_idx;
	logic [4:0]  data_in_idx;

	logic [1:0]  in_rise;
	logic [1:0]  in_fall;
	logic [1:0]  in_level;
	logic        tx_ready;
	logic        tx_busy;
	logic        tx_pin;

	// ==========================================================
	// input edges
	smi_edge_detect #(.WIDTH(2)) u_edges (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.level_in ({local_input_two, local_input_one}),
		.rise     (in_rise),
		.fall     (in_fall),
		.level_q  (in_level)
	);

	// ==========================================================
	// watchdog
	wire wd_expire = ~bus_access & ~wd_tripped & (wd_count >= wd_limit);
	wire [4:0] events = {in_fall[1], in_rise[1], in_fall[0], in_rise[0],
		wd_expire};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wd_count   <= 32'h0;
			wd_tripped <= 1'b0;
		end else if (bus_access) begin
			wd_count   <= 32'h0;
			wd_tripped <= 1'b0;
		end else if (wd_expire) begin
			wd_tripped <= 1'b1;
		end else if (!wd_tripped) begin
			wd_count <= wd_count + 32'h1;
		end
	end

	// ==========================================================
	// command mapping
	function automatic logic [7:0] smi_code(input logic [2:0] sel);
		logic [7:0] code;
		code = 8'h00;
		case (smi_cmd_type'(sel))
			cmd_up:   code = SMI_CODE_UP;
			cmd_down: code = SMI_CODE_DOWN;
			cmd_stop: code = SMI_CODE_STOP;
			cmd_preset_position_one: code = SMI_CODE_PRESET_POSITION_ONE;
			cmd_preset_position_two: code = SMI_CODE_PRESET_POSITION_TWO;
			default:  code = 8'h00;
		endcase
		return code;
	endfunction

	logic [4:0] ev_mapped;
	logic [7:0] ev_code [NUM_EVENTS];
	genvar e;
	generate
		for (e = 0; e < NUM_EVENTS; e++) begin : g_ev
			assign ev_code[e]   = smi_code(cmd_map[3*e +: 3]);
			assign ev_mapped[e] = (ev_code[e] != 8'h00);
		end
	endgenerate

	// lowest pending event wins, then the controller
	logic [2:0] sel_idx;
	always_comb begin
		sel_idx = 3'd7;
		for (int k = NUM_EVENTS - 1; k >= 0; k--) begin
			if (pending[k]) begin
				sel_idx = 3'(k);
			end
		end
	end
	wire       ev_sel     = (sel_idx != 3'd7);
	wire [7:0] sel_code   = ev_sel ? ev_code[sel_idx] : host_code;
	wire       tx_valid   = ev_sel | host_pending;
	wire       tx_take    = tx_valid & tx_ready;
	wire       inputs_on  = |in_level;

	smi_cmd_sender #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.cmd_valid (tx_valid),
		.cmd_code  (sel_code),
		.cmd_ready (tx_ready),
		.smi_tx    (tx_pin),
		.smi_busy  (tx_busy)
	);

	// ==========================================================
	// axi write channel
	logic       aw_held;
	logic       w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	wire        aw_take = s_axi_awvalid & s_axi_awready;
	wire        w_take  = s_axi_wvalid & s_axi_wready;
	wire        wr_fire = aw_held & w_held & ~s_axi_bvalid;
	wire        wr_idx_ok = (aw_addr - REG_DATA_OUT) < 8'(IMAGE_BYTES * 4);
	wire        wr_ok = (aw_addr == REG_CMD_MAP) | (aw_addr == REG_IRQ_STATUS)
		| (aw_addr == REG_IRQ_MASK) | (aw_addr == REG_CTRL_WORD)
		| (aw_addr == REG_WD_LIMIT) | (aw_addr == REG_STATUS_WORD);
	wire        ctrl_wr = wr_fire & (aw_addr == REG_CTRL_WORD) & w_data[15];
	wire        host_req = ctrl_wr & ~inputs_on;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			if (aw_take) begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr[7:0];
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_ok | wr_idx_ok) ? 2'b00 : 2'b10;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_held       <= 1'b0;
				w_held        <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ==========================================================
	// registers
	assign data_out_idx = 5'((aw_addr - REG_DATA_OUT) >> 2);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_map      <= CMD_MAP_RESET;
			irq_mask     <= IRQ_MASK_RESET;
			irq_status   <= 5'h00;
			ctrl_word    <= 16'h0000;
			status_word  <= 16'h0000;
			wd_limit     <= WD_LIMIT_DEFAULT;
			pending      <= 5'h00;
			host_pending <= 1'b0;
			host_code    <= 8'h00;
			last_sent    <= 8'h00;
			for (int j = 0; j < IMAGE_BYTES; j++) begin
				data_out[j] <= 8'h00;
			end
		end else begin
			if (wr_fire && aw_addr == REG_CMD_MAP) begin
				cmd_map <= w_data[14:0];
			end
			if (wr_fire && aw_addr == REG_IRQ_MASK) begin
				irq_mask <= w_data[4:0];
			end
			if (wr_fire && aw_addr == REG_WD_LIMIT) begin
				wd_limit <= w_data;
			end
			if (wr_fire && aw_addr == REG_CTRL_WORD) begin
				ctrl_word <= w_data[15:0];
			end
			if (wr_fire && wr_idx_ok) begin
				data_out[data_out_idx] <= w_data[7:0];
			end
			// set wins over write-one-to-clear
			irq_status <= (irq_status
				& ~((wr_fire && aw_addr == REG_IRQ_STATUS) ? w_data[4:0] : 5'h0))
				| events;
			status_word <= {inputs_on, tx_busy, wd_tripped, 5'h00, last_sent};
			pending <= (pending & ~((tx_take & ev_sel) ? 5'(1 << sel_idx) : 5'h0))
				| (events & ev_mapped);
			if (tx_take) begin
				last_sent <= sel_code;
			end
			if (tx_take & ~ev_sel) begin
				host_pending <= 1'b0;
			end else if (inputs_on) begin
				host_pending <= 1'b0;
			end
			if (host_req) begin
				host_pending <= ctrl_word[15] | 1'b1;
				host_code    <= smi_code(w_data[2:0]);
			end
		end
	end

	// ==========================================================
	// axi read channel
	assign data_in_idx = 5'((s_axi_araddr[7:0] - REG_DATA_IN) >> 2);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int j = 0; j < IMAGE_BYTES; j++) begin
				data_in[j] <= 8'h00;
			end
		end else if (wr_fire && aw_addr == REG_STATUS_WORD
			&& w_data[12:8] < 5'(IMAGE_BYTES)) begin
			data_in[w_data[12:8]] <= w_data[7:0];
		end
	end

	wire [7:0] ra = s_axi_araddr[7:0];
	wire rd_in_ok = (ra - REG_DATA_IN) < 8'(IMAGE_BYTES * 4);
	wire rd_out_ok = (ra - REG_DATA_OUT) < 8'(IMAGE_BYTES * 4);
	wire [4:0] rd_out_idx = 5'((ra - REG_DATA_OUT) >> 2);
	wire rd_map_ok = (ra == REG_CMD_MAP) | (ra == REG_STATUS)
		| (ra == REG_IRQ_STATUS) | (ra == REG_IRQ_MASK)
		| (ra == REG_CTRL_WORD) | (ra == REG_STATUS_WORD)
		| (ra == REG_WD_LIMIT);
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0;
		case (ra)
			REG_CMD_MAP:     rd_word = {17'h0, cmd_map};
			REG_STATUS:      rd_word = {29'h0, wd_tripped, in_level};
			REG_IRQ_STATUS:  rd_word = {27'h0, irq_status};
			REG_IRQ_MASK:    rd_word = {27'h0, irq_mask};
			REG_CTRL_WORD:   rd_word = {16'h0, ctrl_word};
			REG_STATUS_WORD: rd_word = {16'h0, status_word};
			REG_WD_LIMIT:    rd_word = wd_limit;
			default:         rd_word = rd_in_ok ? {24'h0, data_in[data_in_idx]}
				: rd_out_ok ? {24'h0, data_out[rd_out_idx]} : 32'h0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'b00;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= (rd_map_ok | rd_in_ok | rd_out_ok)
				? 2'b00 : 2'b10;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq          <= 1'b0;
			input_active <= 1'b0;
			smi_tx       <= 1'b1;
		end else begin
			irq          <= |(irq_status & irq_mask);
			input_active <= inputs_on;
			smi_tx       <= tx_pin;
		end
	end

endmodule

//--- include/smi_pkg.sv
package smi_pkg;

	// ==========================================================
	// event and command codes
	typedef enum logic [2:0] {
		cmd_none  = 3'b000,
		cmd_up    = 3'b001,
		cmd_down  = 3'b010,
		cmd_stop  = 3'b011,
		cmd_preset_position_one  = 3'b100,
		cmd_preset_position_two  = 3'b101
	} smi_cmd_type;

	localparam int unsigned NUM_EVENTS     = 5;
	localparam int unsigned EV_WATCHDOG    = 0;
	localparam int unsigned EV_IN1_RISE    = 1;
	localparam int unsigned EV_IN1_FALL    = 2;
	localparam int unsigned EV_IN2_RISE    = 3;
	localparam int unsigned EV_IN2_FALL    = 4;

	// ==========================================================
	// motor bus command codes sent on the wire
	localparam logic [7:0] SMI_CODE_UP    = 8'h01;
	localparam logic [7:0] SMI_CODE_DOWN  = 8'h02;
	localparam logic [7:0] SMI_CODE_STOP  = 8'h03;
	localparam logic [7:0] SMI_CODE_PRESET_POSITION_ONE  = 8'h04;
	localparam logic [7:0] SMI_CODE_PRESET_POSITION_TWO  = 8'h05;

	// ==========================================================
	// process image layout
	localparam int unsigned STATUS_BITS    = 16;
	localparam int unsigned CTRL_BITS      = 16;
	localparam int unsigned IMAGE_BYTES    = 22;
	localparam int unsigned LAST_IMAGE_BYTE = 23;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] REG_CMD_MAP     = 8'h00;
	localparam logic [7:0] REG_STATUS      = 8'h04;
	localparam logic [7:0] REG_IRQ_STATUS  = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK    = 8'h0c;
	localparam logic [7:0] REG_CTRL_WORD   = 8'h10;
	localparam logic [7:0] REG_DATA_OUT    = 8'h40;
	localparam logic [7:0] REG_STATUS_WORD = 8'h18;
	localparam logic [7:0] REG_DATA_IN     = 8'h98;
	localparam logic [7:0] REG_WD_LIMIT    = 8'h20;

	localparam logic [14:0] CMD_MAP_RESET  = 15'h0000;
	localparam logic [4:0]  IRQ_MASK_RESET = 5'h00;

	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ         = 25000000;
	localparam int unsigned WD_TIME_MS     = 100;
	localparam int unsigned WD_CYCLES      = CLK_HZ / 1000 * WD_TIME_MS;
	localparam int unsigned SMI_BIT_NS     = 40000;
	localparam int unsigned SMI_BIT_CYCLES = SMI_BIT_NS / 40;

endpackage

//--- rtl/smi_edge_detect.sv
`timescale 1ns/100ps
module smi_edge_detect
	import smi_pkg::*;
#(
	parameter int unsigned WIDTH = 2
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] level_in,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall,
	output logic      [WIDTH-1:0] level_q
);

	// ==========================================================
	// per input edge detection
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					level_q[i] <= 1'b0;
				end else begin
					level_q[i] <= level_in[i];
				end
			end
			assign rise[i] = level_in[i] & ~level_q[i];
			assign fall[i] = ~level_in[i] & level_q[i];
		end
	endgenerate

endmodule

//--- rtl/smi_cmd_sender.sv
`timescale 1ns/100ps
module smi_cmd_sender
	import smi_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = SMI_BIT_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_code,
	output logic             cmd_ready,
	output logic             smi_tx,
	output logic             smi_busy
);

	// ==========================================================
	// frame: start bit 0, eight data bits lsb first, stop bit 1
	localparam int unsigned CW = $clog2(BIT_CYCLES + 1);

	logic [CW-1:0] bit_timer;
	logic [3:0]    bit_count;
	logic [9:0]    shift;
	wire           bit_tick = (bit_timer == CW'(BIT_CYCLES - 1));

	assign cmd_ready = ~smi_busy;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			smi_busy  <= 1'b0;
			smi_tx    <= 1'b1;
			bit_timer <= '0;
			bit_count <= 4'h0;
			shift     <= 10'h3ff;
		end else if (!smi_busy) begin
			if (cmd_valid) begin
				smi_busy  <= 1'b1;
				shift     <= {1'b1, cmd_code, 1'b0};
				smi_tx    <= 1'b0;
				bit_timer <= '0;
				bit_count <= 4'h0;
			end
		end else if (bit_tick) begin
			bit_timer <= '0;
			if (bit_count == 4'h9) begin
				smi_busy <= 1'b0;
				smi_tx   <= 1'b1;
			end else begin
				bit_count <= bit_count + 4'h1;
				smi_tx    <= shift[bit_count + 4'h1];
			end
		end else begin
			bit_timer <= bit_timer + CW'(1);
		end
	end

endmodule

//--- testbench/smi_drive_model.sv
`timescale 1ns/100ps
module smi_drive_model #(
	parameter int unsigned BIT_CYCLES = 4
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        smi_tx,
	output logic      [7:0]  rx_code,
	output logic      [15:0] rx_count,
	output logic             rx_bad
);
	// ==========
	// frame receiver, samples each bit mid cell
	int unsigned pos;
	logic [7:0]  sh;
	always @(posedge aclk) begin
		if (!aresetn) begin
			pos      <= 0;
			sh       <= 8'h00;
			rx_code  <= 8'h00;
			rx_count <= 16'h0000;
			rx_bad   <= 1'b0;
		end else if (pos != 0 || !smi_tx) begin
			pos <= (pos == 10 * BIT_CYCLES - 1) ? 0 : pos + 1;
			if (pos % BIT_CYCLES == BIT_CYCLES / 2) begin
				if (pos / BIT_CYCLES inside {[1:8]})
					sh[pos / BIT_CYCLES - 1] <= smi_tx;
				if (pos == BIT_CYCLES / 2 && smi_tx)
					rx_bad <= 1'b1;
			end
			if (pos == 9 * BIT_CYCLES + BIT_CYCLES / 2) begin
				rx_code  <= sh;
				rx_count <= rx_count + 16'h0001;
				rx_bad   <= rx_bad | !smi_tx;
			end
		end
	end
endmodule

//--- testbench/smi_event_trigger_assertions.sv
`timescale 1ns/100ps
module smi_event_trigger_assertions #(
	parameter int unsigned BIT_CYCLES = 4
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       local_input_one,
	input wire logic       local_input_two,
	input wire logic       smi_tx,
	input wire logic       input_active,
	input wire logic       irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========
	// position within a motor frame
	logic [7:0] fcnt;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			fcnt <= 8'h00;
		else if (fcnt != 8'h00 || !smi_tx)
			fcnt <= (fcnt == 8'(10 * BIT_CYCLES - 1)) ? 8'h00 : fcnt + 8'h01;
	end
	// ==========
	// checks
	chk_reset_idle: assert property (!$past(aresetn) |-> smi_tx && !irq
		&& !s_axi_bvalid && !s_axi_rvalid && !input_active)
		else $error("outputs not idle after reset");
	chk_input_follow: assert property ($past(aresetn) |->
		input_active == $past(local_input_one | local_input_two, 2))
		else $error("input_active does not follow inputs");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read data late");
	chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid kept after handshake");
	chk_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid kept after handshake");
	chk_write_blocked: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	chk_start_bit: assert property (fcnt != 8'h00
		&& fcnt < 8'(BIT_CYCLES) |-> !smi_tx)
		else $error("start bit too short");
	chk_bit_steady: assert property (fcnt != 8'h00
		&& fcnt % 8'(BIT_CYCLES) != 8'h00 |-> $stable(smi_tx))
		else $error("line changed inside a bit");
	chk_stop_bit: assert property (fcnt >= 8'(9 * BIT_CYCLES) |-> smi_tx)
		else $error("stop bit missing");
	cov_frame: cover property ($fell(smi_tx));
	cov_irq: cover property ($rose(irq));
	cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind smi_event_trigger smi_event_trigger_assertions #(
	.BIT_CYCLES(BIT_CYCLES)
) u_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.local_input_one, .local_input_two, .smi_tx, .input_active, .irq
);

//--- testbench/tb.sv
`timescale 1ns/100ps
module tb;
	import smi_pkg::*;
	// ==========
	// signals
	logic        aclk = 1'b0, aresetn = 1'b0, bus_access = 1'b1;
	logic        local_input_one = 1'b0, local_input_two = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd, seed = 32'd48;
	logic        smi_tx, input_active, irq, rx_bad;
	logic [7:0]  rx_code;
	logic [15:0] rx_count;
	int          err_total = 0, check_count = 0, c, ev;
	always #20 aclk = ~aclk;
	smi_event_trigger #(.WD_LIMIT_DEFAULT(50), .BIT_CYCLES(4)) uut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .bus_access, .local_input_one,
		.local_input_two, .smi_tx, .input_active, .irq);
	smi_drive_model #(.BIT_CYCLES(4)) drive (.aclk, .aresetn, .smi_tx,
		.rx_code, .rx_count, .rx_bad);
	// ==========
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] code_of(input int k);
		case (k)
			1: return SMI_CODE_UP;
			2: return SMI_CODE_DOWN;
			3: return SMI_CODE_STOP;
			4: return SMI_CODE_PRESET_POSITION_ONE;
			default: return SMI_CODE_PRESET_POSITION_TWO;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw = 1'b0, w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr  <= 32'(a);
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			aw |= s_axi_awready;
			w |= s_axi_wready;
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr  <= 32'(a);
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic set_in(input int k, input logic v);
		@(posedge aclk);
		if (k < 3)
			local_input_one <= v;
		else
			local_input_two <= v;
	endtask
	// zero code means no frame at all
	task automatic frame(input logic [7:0] code);
		logic [15:0] c0;
		c0 = rx_count;
		repeat (150) @(posedge aclk);
		chk("frame count", 32'(rx_count - c0), 32'(code != 8'h00));
		if (code != 8'h00)
			chk("frame code", 32'(rx_code), 32'(code));
	endtask
	task automatic finish_test();
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========
	// hang guard, several times the expected run
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		finish_test();
	end
	// ==========
	// main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axr(REG_CMD_MAP);
		chk("map reset", rd, 32'(CMD_MAP_RESET));
		axr(REG_IRQ_MASK);
		chk("mask reset", rd, 32'(IRQ_MASK_RESET));
		axr(8'hfc);
		chk("bad read", 32'(resp), 32'h2);
		axw(8'hfc, 32'h1);
		chk("bad write", 32'(resp), 32'h2);
		ev = int'(rnd() & 32'hff);
		axw(REG_DATA_OUT + 8'h04, 32'(ev));
		axr(REG_DATA_OUT + 8'h04);
		chk("data out", rd, 32'(ev));
		axw(REG_STATUS_WORD, (32'(IMAGE_BYTES - 1) << 8) | 32'(ev));
		axr(REG_DATA_IN + 8'((IMAGE_BYTES - 1) * 4));
		chk("data in", rd, 32'(ev));
		for (c = 1; c <= 5; c++) begin
			axw(REG_CMD_MAP, 32'(c) << 3);
			set_in(1, 1'b1);
			frame(code_of(c));
			set_in(1, 1'b0);
			frame(8'h00);
		end
		for (int i = 0; i < 8; i++) begin
			ev = 1 + i % 4;
			c = 1 + int'(rnd() % 5);
			axw(REG_CMD_MAP, 32'(c) << (3 * ev));
			set_in(ev, 1'b1);
			frame(ev % 2 ? code_of(c) : 8'h00);
			set_in(ev, 1'b0);
			frame(ev % 2 ? 8'h00 : code_of(c));
		end
		axr(REG_IRQ_STATUS);
		chk("event flags", rd, 32'h1e);
		chk("irq masked", 32'(irq), 32'h0);
		axw(REG_IRQ_MASK, 32'h04);
		repeat (2) @(posedge aclk);
		chk("irq raised", 32'(irq), 32'h1);
		axw(REG_IRQ_STATUS, 32'h1e);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 32'(irq), 32'h0);
		axw(REG_CMD_MAP, 32'(cmd_stop));
		bus_access <= 1'b0;
		frame(SMI_CODE_STOP);
		axr(REG_STATUS);
		chk("watchdog flag", 32'(rd[2:0]), 32'h4);
		bus_access <= 1'b1;
		axw(REG_CMD_MAP, 32'h0);
		axw(REG_CTRL_WORD, 32'h8000 | 32'(cmd_down));
		frame(SMI_CODE_DOWN);
		axr(REG_STATUS_WORD);
		chk("last sent", 32'(rd[7:0]), 32'(SMI_CODE_DOWN));
		set_in(3, 1'b1);
		axw(REG_CTRL_WORD, 32'h8000 | 32'(cmd_up));
		frame(8'h00);
		chk("input active", 32'(input_active), 32'h1);
		set_in(3, 1'b0);
		frame(8'h00);
		chk("framing", 32'(rx_bad), 32'h0);
		finish_test();
	end
endmodule
